// [pkg/ffl_defs.svh]
// register offsets, field positions and reset values of the loop control block
`ifndef FFL_DEFS_SVH
`define FFL_DEFS_SVH

`define FFL_ADDR_W          8
`define FFL_DATA_W          16

`define FFL_ADDR_CTRL1      8'h9b
`define FFL_ADDR_CTRL2      8'h9c
`define FFL_ADDR_RATIO      8'h9d
`define FFL_ADDR_RSVD       8'h9e
`define FFL_ADDR_NUM        8'ha0
`define FFL_ADDR_DEN        8'ha1
`define FFL_ADDR_INTM       8'ha2
`define FFL_ADDR_STATUS     8'ha3
`define FFL_ADDR_SRC        8'ha4

`define FFL_EN_BIT          0
`define FFL_FRAC_BIT        2
`define FFL_RSV1_BIT        3
`define FFL_OUTDIV_MSB      8
`define FFL_OUTDIV_LSB      3
`define FFL_REFDIV_MSB      1
`define FFL_REFDIV_LSB      0
`define FFL_RATIO_MSB       2
`define FFL_RATIO_LSB       0
`define FFL_RSV3_MSB        8
`define FFL_RSV3_LSB        4
`define FFL_RSV4_MSB        3
`define FFL_RSV4_LSB        0
`define FFL_INTM_MSB        9
`define FFL_SRC_MSB         1

`define FFL_RST_EN          1'b0
`define FFL_RST_FRAC        1'b1
`define FFL_RST_RSV1        1'b1
`define FFL_RST_OUTDIV      6'h07
`define FFL_RST_REFDIV      2'h1
`define FFL_RST_RATIO       3'h0
`define FFL_RST_RSV3        5'h18
`define FFL_RST_RSV4        4'h0
`define FFL_RST_NUM         16'h0018
`define FFL_RST_DEN         16'h007d
`define FFL_RST_INTM        10'h008
`define FFL_RST_SRC         2'h0

`endif

// [pkg/ffl_pkg.sv]
// types shared by the loop control block
`default_nettype none
package ffl_pkg;

  typedef enum logic [1:0] {
    FFL_SRC_MASTER = 2'h0,
    FFL_SRC_BIT    = 2'h1,
    FFL_SRC_OSC    = 2'h2,
    FFL_SRC_NONE   = 2'h3
  } ffl_src_t;

  typedef enum logic [1:0] {
    FFL_ST_IDLE = 2'h0,
    FFL_ST_ACQ  = 2'h1,
    FFL_ST_LOCK = 2'h3
  } ffl_state_t;

endpackage
`default_nettype wire

// [rtl/ffl_ref_div.sv]
// reference source selection and reference pre-divider
`timescale 1ns/1ps
`default_nettype none
module ffl_ref_div (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_master_clk,
  input  wire logic       i_bit_clk,
  input  wire logic       i_osc_clk,
  input  wire logic [1:0] i_src_sel,
  input  wire logic [1:0] i_div_code,
  input  wire logic       i_clear,
  output logic            o_ref_tick
);
  logic       ref_lvl;
  logic       prev_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] term;
  logic       div_ok;
  logic       edge_ok;
  logic       tick_nxt;

  // source mux; the reserved code gives no reference
  assign ref_lvl = (i_src_sel == ffl_pkg::FFL_SRC_MASTER) ? i_master_clk :
                   (i_src_sel == ffl_pkg::FFL_SRC_BIT)    ? i_bit_clk    :
                   (i_src_sel == ffl_pkg::FFL_SRC_OSC)    ? i_osc_clk    : 1'b0;
  // divide by 1, 2 or 4; code 3 stops the reference
  assign term     = (i_div_code == 2'h0) ? 2'h0 : (i_div_code == 2'h1) ? 2'h1 : 2'h3;
  assign div_ok   = (i_div_code != 2'h3);
  assign edge_ok  = ref_lvl && !prev_r && div_ok && !i_clear;
  assign tick_nxt = edge_ok && (cnt_r == term);
  assign cnt_nxt  = i_clear ? 2'h0 : !edge_ok ? cnt_r : (cnt_r == term) ? 2'h0 : cnt_r + 2'h1;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prev_r     <= 1'b0;
      cnt_r      <= 2'h0;
      o_ref_tick <= 1'b0;
    end else begin
      prev_r     <= ref_lvl;
      cnt_r      <= cnt_nxt;
      o_ref_tick <= tick_nxt;
    end
  end
endmodule // ffl_ref_div
`default_nettype wire

// [rtl/ffl_nco.sv]
// fractional accumulator that turns reference ticks into output clock edges
`timescale 1ns/1ps
`default_nettype none
module ffl_nco #(
  parameter int ACC_W = 40,
  parameter int INC_W = 34,
  parameter int THR_W = 23
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clear,
  input  wire logic             i_tick,
  input  wire logic [INC_W-1:0] i_incr,
  input  wire logic [THR_W-1:0] i_thresh,
  output logic                  o_clk
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] add_v;
  logic [ACC_W-1:0] sub_v;
  logic             over;

  // credit is counted in half operating periods scaled by the denominator;
  // at most one edge per cycle, so a burst of credit drains over cycles
  assign over    = (i_thresh != '0) && (acc_r >= ACC_W'(i_thresh));
  assign add_v   = i_tick ? ACC_W'(i_incr) : '0;
  assign sub_v   = over ? ACC_W'(i_thresh) : '0;
  assign acc_nxt = i_clear ? '0 : acc_r + add_v - sub_v;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      acc_r <= '0;
      o_clk <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      o_clk <= i_clear ? 1'b0 : (o_clk ^ over);
    end
  end
endmodule // ffl_nco
`default_nettype wire

// [rtl/ffl_ctrl.sv]
// frequency locked loop control: registers, multiplier arithmetic and lock tracking
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ffl_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - reference chosen from master, bit, oscillator
// - enable bit 0 turns loop on, resets off
// - reference divider 1,2,4; resets to /2
// - output clock is operating frequency over divider
// - operating frequency is reference times N.K times ratio
// - output divider code is ratio minus one
// - ratio codes give 1,2,4,8,16; resets 000
// - integer multiplier ten bits, resets to 8
// - fraction ignored in integer mode
// - mode bit 2 selects fractional, resets 1
// - numerator and denominator reset 0018h, 007Dh
module ffl_ctrl #(
  parameter int LOCK_TICKS = 16
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_master_clk,
  input  wire logic                    i_bit_clk,
  input  wire logic                    i_osc_clk,
  input  wire logic [`FFL_ADDR_W-1:0]  i_addr,
  input  wire logic [`FFL_DATA_W-1:0]  i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [`FFL_DATA_W-1:0]  o_rdata,
  output logic                         o_system_clock,
  output logic                         o_locked
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [4:0] ratio_of(input logic [2:0] code);
    ratio_of = code[2] ? 5'h10 : (5'h01 << code[1:0]);
  endfunction

  function automatic logic [6:0] outdiv_of(input logic [5:0] code);
    outdiv_of = {1'b0, code} + 7'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  logic                 loop_enable_r;
  logic                 loop_fractional_mode_r;
  logic                 rsv1_r;
  logic [5:0]           loop_output_divider_r;
  logic [1:0]           loop_ref_divider_r;
  logic [2:0]           loop_ref_ratio_r;
  logic [4:0]           rsv3_r;
  logic [3:0]           rsv4_r;
  logic [15:0]          loop_frac_numerator_r;
  logic [15:0]          loop_frac_denominator_r;
  logic [9:0]           loop_integer_mult_r;
  logic [1:0]           loop_ref_source_sel_r;
  ffl_pkg::ffl_state_t  state_r;
  ffl_pkg::ffl_state_t  state_nxt;
  logic [15:0]          lock_cnt_r;
  logic [15:0]          lock_cnt_nxt;

  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_ratio;
  logic wr_rsvd;
  logic wr_num;
  logic wr_den;
  logic wr_intm;
  logic wr_src;

  assign wr_ctrl1 = i_wr && (i_addr == `FFL_ADDR_CTRL1);
  assign wr_ctrl2 = i_wr && (i_addr == `FFL_ADDR_CTRL2);
  assign wr_ratio = i_wr && (i_addr == `FFL_ADDR_RATIO);
  assign wr_rsvd  = i_wr && (i_addr == `FFL_ADDR_RSVD);
  assign wr_num   = i_wr && (i_addr == `FFL_ADDR_NUM);
  assign wr_den   = i_wr && (i_addr == `FFL_ADDR_DEN);
  assign wr_intm  = i_wr && (i_addr == `FFL_ADDR_INTM);
  assign wr_src   = i_wr && (i_addr == `FFL_ADDR_SRC);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      loop_enable_r          <= `FFL_RST_EN;
      loop_fractional_mode_r <= `FFL_RST_FRAC;
      rsv1_r                 <= `FFL_RST_RSV1;
    end else if (wr_ctrl1) begin
      loop_enable_r          <= i_wdata[`FFL_EN_BIT];
      loop_fractional_mode_r <= i_wdata[`FFL_FRAC_BIT];
      rsv1_r                 <= i_wdata[`FFL_RSV1_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      loop_output_divider_r <= `FFL_RST_OUTDIV;
      loop_ref_divider_r    <= `FFL_RST_REFDIV;
    end else if (wr_ctrl2) begin
      loop_output_divider_r <= i_wdata[`FFL_OUTDIV_MSB:`FFL_OUTDIV_LSB];
      loop_ref_divider_r    <= i_wdata[`FFL_REFDIV_MSB:`FFL_REFDIV_LSB];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      loop_ref_ratio_r <= `FFL_RST_RATIO;
      rsv3_r           <= `FFL_RST_RSV3;
      rsv4_r           <= `FFL_RST_RSV4;
    end else begin
      if (wr_ratio) begin
        loop_ref_ratio_r <= i_wdata[`FFL_RATIO_MSB:`FFL_RATIO_LSB];
        rsv3_r           <= i_wdata[`FFL_RSV3_MSB:`FFL_RSV3_LSB];
      end
      if (wr_rsvd) begin
        rsv4_r <= i_wdata[`FFL_RSV4_MSB:`FFL_RSV4_LSB];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      loop_frac_numerator_r   <= `FFL_RST_NUM;
      loop_frac_denominator_r <= `FFL_RST_DEN;
      loop_integer_mult_r     <= `FFL_RST_INTM;
      loop_ref_source_sel_r   <= `FFL_RST_SRC;
    end else begin
      if (wr_num) begin
        loop_frac_numerator_r <= i_wdata;
      end
      if (wr_den) begin
        loop_frac_denominator_r <= i_wdata;
      end
      if (wr_intm) begin
        loop_integer_mult_r <= i_wdata[`FFL_INTM_MSB:0];
      end
      if (wr_src) begin
        loop_ref_source_sel_r <= i_wdata[`FFL_SRC_MSB:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data stand only in the cycle after the strobe

  logic [15:0] rd_mux;

  assign rd_mux =
    (i_addr == `FFL_ADDR_CTRL1)  ? {12'h000, rsv1_r, loop_fractional_mode_r, 1'b0, loop_enable_r} :
    (i_addr == `FFL_ADDR_CTRL2)  ? {7'h00, loop_output_divider_r, 1'b0, loop_ref_divider_r} :
    (i_addr == `FFL_ADDR_RATIO)  ? {7'h00, rsv3_r, 1'b0, loop_ref_ratio_r} :
    (i_addr == `FFL_ADDR_RSVD)   ? {12'h000, rsv4_r} :
    (i_addr == `FFL_ADDR_NUM)    ? loop_frac_numerator_r :
    (i_addr == `FFL_ADDR_DEN)    ? loop_frac_denominator_r :
    (i_addr == `FFL_ADDR_INTM)   ? {6'h00, loop_integer_mult_r} :
    (i_addr == `FFL_ADDR_STATUS) ? {14'h0000, state_r} :
    (i_addr == `FFL_ADDR_SRC)    ? {14'h0000, loop_ref_source_sel_r} : 16'h0000;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // multiplier arithmetic

  logic        loop_clear;
  logic        ref_tick;
  logic [25:0] n_times_den;
  logic [26:0] nk_scaled;
  logic [33:0] loop_incr;
  logic [22:0] loop_thresh;
  logic [15:0] frac_term;

  // a disabled loop drops all credit, so re-enabling starts from zero
  assign loop_clear  = !loop_enable_r;
  assign frac_term   = loop_fractional_mode_r ? loop_frac_numerator_r : 16'h0000;
  assign n_times_den = 26'(loop_integer_mult_r) * 26'(loop_frac_denominator_r);
  assign nk_scaled   = 27'(n_times_den) + 27'(frac_term);
  // two edges per output period, hence the factor of two
  assign loop_incr   = 34'(ratio_of(loop_ref_ratio_r)) * 34'(nk_scaled) * 34'h2;
  assign loop_thresh = 23'(outdiv_of(loop_output_divider_r)) * 23'(loop_frac_denominator_r);

  ffl_ref_div u_ref_div (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_master_clk (i_master_clk),
    .i_bit_clk    (i_bit_clk),
    .i_osc_clk    (i_osc_clk),
    .i_src_sel    (loop_ref_source_sel_r),
    .i_div_code   (loop_ref_divider_r),
    .i_clear      (loop_clear),
    .o_ref_tick   (ref_tick)
  );

  ffl_nco #(
    .ACC_W (40),
    .INC_W (34),
    .THR_W (23)
  ) u_nco (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_clear  (loop_clear),
    .i_tick   (ref_tick),
    .i_incr   (loop_incr),
    .i_thresh (loop_thresh),
    .o_clk    (o_system_clock)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // acquisition tracking

  always_comb begin
    state_nxt    = state_r;
    lock_cnt_nxt = lock_cnt_r;
    case (state_r)
      ffl_pkg::FFL_ST_IDLE: begin
        lock_cnt_nxt = 16'h0000;
        if (loop_enable_r) begin
          state_nxt = ffl_pkg::FFL_ST_ACQ;
        end
      end
      ffl_pkg::FFL_ST_ACQ: begin
        if (ref_tick) begin
          lock_cnt_nxt = lock_cnt_r + 16'h0001;
        end
        if (ref_tick && (lock_cnt_r == 16'(LOCK_TICKS - 1))) begin
          state_nxt = ffl_pkg::FFL_ST_LOCK;
        end
      end
      ffl_pkg::FFL_ST_LOCK: begin
        state_nxt = ffl_pkg::FFL_ST_LOCK;
      end
      default: begin
        state_nxt = ffl_pkg::FFL_ST_IDLE;
      end
    endcase
    if (!loop_enable_r) begin
      state_nxt    = ffl_pkg::FFL_ST_IDLE;
      lock_cnt_nxt = 16'h0000;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r    <= ffl_pkg::FFL_ST_IDLE;
      lock_cnt_r <= 16'h0000;
    end else begin
      state_r    <= state_nxt;
      lock_cnt_r <= lock_cnt_nxt;
    end
  end

  assign o_locked = (state_r == ffl_pkg::FFL_ST_LOCK);

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_wr_ctrl1;
    i_wr && (i_addr == `FFL_ADDR_CTRL1);
  endsequence

  sequence s_disable;
    i_wr && (i_addr == `FFL_ADDR_CTRL1) && !i_wdata[`FFL_EN_BIT];
  endsequence

  sequence s_last_tick;
    ref_tick && (state_r == ffl_pkg::FFL_ST_ACQ) && (lock_cnt_r == 16'(LOCK_TICKS - 1));
  endsequence

  enable_write_a: assert property (s_wr_ctrl1 |=> loop_enable_r == $past(i_wdata[0]))
    else $error("enable bit did not follow the write");

  frac_write_a: assert property (s_wr_ctrl1 |=> loop_fractional_mode_r == $past(i_wdata[2]))
    else $error("mode bit did not follow the write");

  reset_values_a: assert property ($past(i_reset) |->
      loop_frac_numerator_r == 16'h0018 && loop_frac_denominator_r == 16'h007d &&
      loop_integer_mult_r == 10'h008 && loop_output_divider_r == 6'h07 &&
      loop_ref_divider_r == 2'h1 && loop_ref_ratio_r == 3'h0 &&
      loop_fractional_mode_r && !loop_enable_r)
    else $error("register reset value wrong");

  clock_low_a: assert property (s_disable ##1 1'b1 |=> !o_system_clock [*4])
    else $error("output clock not held low while disabled");

  restart_a: assert property (s_disable |=> ##1 state_r == ffl_pkg::FFL_ST_IDLE && !o_locked)
    else $error("acquisition not restarted after disable");

  int_ignore_a: assert property (!loop_fractional_mode_r && $stable(loop_integer_mult_r) &&
      $stable(loop_frac_denominator_r) && $stable(loop_ref_ratio_r) && $stable(loop_fractional_mode_r)
      |-> $stable(loop_incr))
    else $error("fraction altered the increment in integer mode");

  mult_read_a: assert property (i_rd && i_addr == `FFL_ADDR_INTM && !i_wr
      |=> o_rdata == {6'h00, $past(loop_integer_mult_r)})
    else $error("integer multiplier read back wrong");

  ratio_map_a: assert property (loop_ref_ratio_r[2] |-> loop_incr == 34'(nk_scaled) * 34'h20)
    else $error("ratio code 1xx is not sixteen");

  outdiv_map_a: assert property (loop_output_divider_r == 6'h07
      |-> loop_thresh == 23'(loop_frac_denominator_r) * 23'h8)
    else $error("output divider code not ratio minus one");

  ref_stop_a: assert property (loop_ref_divider_r == 2'h3 && $past(loop_ref_divider_r) == 2'h3
      |-> !ref_tick)
    else $error("reserved divider code produced a reference tick");

  src_read_a: assert property (i_rd && i_addr == `FFL_ADDR_SRC && !i_wr
      |=> o_rdata[1:0] == $past(loop_ref_source_sel_r))
    else $error("source select read back wrong");

  // status lags the enable bit by one cycle, so the lock flag is held against the previous enable
  lock_enable_a: assert property (o_locked |-> $past(loop_enable_r))
    else $error("lock reported while disabled");

  lock_entry_a: assert property (s_last_tick ##0 loop_enable_r |=> o_locked)
    else $error("lock not reported after the counted ticks");

  restart_acq_a: assert property ($rose(loop_enable_r) |-> !o_system_clock ##1 state_r == ffl_pkg::FFL_ST_ACQ)
    else $error("acquisition did not restart from a cleared loop");

endmodule // ffl_ctrl
`default_nettype wire

// [tb/ffl_ref_src.sv]
// free-running reference clock sources that feed the loop's source selector
`timescale 1ns/1ps
`default_nettype none
module ffl_ref_src #(
  parameter int HALF_M = 513,
  parameter int HALF_B = 617,
  parameter int HALF_O = 771
) (
  output logic o_master_clk,
  output logic o_bit_clk,
  output logic o_osc_clk
);
  // three unrelated rates, so a wrong source selection shows up as a wrong edge count
  initial begin
    o_master_clk = 1'b0;
    o_bit_clk    = 1'b0;
    o_osc_clk    = 1'b0;
  end
  always #(HALF_M) o_master_clk = ~o_master_clk;
  always #(HALF_B) o_bit_clk = ~o_bit_clk;
  always #(HALF_O) o_osc_clk = ~o_osc_clk;
endmodule // ffl_ref_src
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
`include "ffl_defs.svh"
module testbench;
  logic        i_clk;
  logic        i_reset;
  logic        m_clk;
  logic        b_clk;
  logic        osc_clk;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic        o_system_clock;
  logic        o_locked;
  logic [15:0] rd_val;
  int          bad_count = 0;
  int          cmp_count = 0;
  // src, refdiv code, ratio code, n, frac, num, den, outdiv code
  int          rows [8][8] = '{'{0, 0, 0, 4, 0, 24, 125, 1}, '{1, 1, 1, 3, 1, 1, 2, 6},
                               '{2, 2, 4, 1, 0, 5, 7, 15}, '{0, 0, 2, 2, 0, 1, 1, 7},
                               '{1, 0, 3, 1, 1, 1, 3, 15}, '{0, 0, 5, 1, 0, 1, 1, 31},
                               '{0, 3, 0, 4, 0, 1, 1, 1}, '{3, 0, 0, 4, 0, 1, 1, 1}};

  ffl_ctrl #(.LOCK_TICKS(2)) ffl_ctrl_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_master_clk(m_clk), .i_bit_clk(b_clk), .i_osc_clk(osc_clk),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_system_clock(o_system_clock), .o_locked(o_locked));
  ffl_ref_src ffl_ref_src_i (.o_master_clk(m_clk), .o_bit_clk(b_clk), .o_osc_clk(osc_clk));

  initial i_clk = 1'b0;
  always #25 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // counts are derived by the bench, so a tolerance covers divider phase and toggle backlog
  task automatic chk_cnt(input string nm, input int exp, input int got, input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rdata;
  endtask

  function automatic logic ref_level(input int src);
    return (src == 0) ? m_clk : (src == 1) ? b_clk : (src == 2) ? osc_clk : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    logic [7:0]  a [10] = '{8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'h9f};
    logic [15:0] e [10] = '{16'h000c, 16'h0039, 16'h0180, 16'h0000, 16'h0018, 16'h007d, 16'h0008,
                            16'h0000, 16'h0000, 16'h0000};
    chk("system clock at reset", 16'h0000, {15'h0000, o_system_clock});
    for (int k = 0; k < 10; k++) begin
      rd(a[k]);
      chk("reset value", e[k], rd_val);
    end
  endtask

  task automatic test_access();
    wr(`FFL_ADDR_STATUS, 16'hffff);
    rd(`FFL_ADDR_STATUS);
    chk("status after write", 16'h0000, rd_val);
    wr(8'h9f, 16'hffff);
    rd(8'h9f);
    chk("unmapped read", 16'h0000, rd_val);
    wr(`FFL_ADDR_CTRL1, 16'h000a);
    rd(`FFL_ADDR_CTRL1);
    chk("mode and enable", 16'h0008, rd_val);
    wr(`FFL_ADDR_NUM, 16'hffff);
    rd(`FFL_ADDR_NUM);
    chk("numerator width", 16'hffff, rd_val);
    wr(`FFL_ADDR_INTM, 16'h03ff);
    rd(`FFL_ADDR_INTM);
    chk("multiplier width", 16'h03ff, rd_val);
    chk("system clock disabled", 16'h0000, {15'h0000, o_system_clock});
  endtask

  task automatic run_case(input int r [8]);
    int d;
    int rat;
    int pn;
    int pd;
    int ex;
    int tol;
    int e;
    int t;
    logic ref_p;
    logic ref_c;
    logic clk_p;
    d   = (r[1] == 3 || r[0] == 3) ? 0 : (1 << r[1]);
    rat = (r[2] > 3) ? 16 : (1 << r[2]);
    pn  = 2 * rat * (r[3] * r[6] + (r[4] != 0 ? r[5] : 0));
    pd  = (r[7] + 1) * r[6];
    wr(`FFL_ADDR_CTRL1, 16'h0008 | 16'(r[4] << 2));
    wr(`FFL_ADDR_SRC, 16'(r[0]));
    wr(`FFL_ADDR_CTRL2, 16'((r[7] << 3) | r[1]));
    wr(`FFL_ADDR_RATIO, 16'h0180 | 16'(r[2]));
    wr(`FFL_ADDR_NUM, 16'(r[5]));
    wr(`FFL_ADDR_DEN, 16'(r[6]));
    wr(`FFL_ADDR_INTM, 16'(r[3]));
    rd(`FFL_ADDR_CTRL2);
    chk("divider fields", 16'((r[7] << 3) | r[1]), rd_val);
    wr(`FFL_ADDR_CTRL1, 16'h0009 | 16'(r[4] << 2));
    if (d != 0) begin
      t = 0;
      while (o_locked !== 1'b1 && t < 1000) begin
        @(posedge i_clk);
        #1;
        t++;
      end
      chk("lock flag", 16'h0001, {15'h0000, o_locked});
      rd(`FFL_ADDR_STATUS);
      chk("lock state", 16'h0003, rd_val);
    end else begin
      repeat (200) @(posedge i_clk);
    end
    // outputs are looked at just after the edge, once they have settled
    #1;
    e = 0;
    t = 0;
    ref_p = ref_level(r[0]);
    clk_p = o_system_clock;
    repeat (1600) begin
      @(posedge i_clk);
      #1;
      ref_c = ref_level(r[0]);
      if (ref_c && !ref_p) e++;
      ref_p = ref_c;
      if (o_system_clock !== clk_p) t++;
      clk_p = o_system_clock;
    end
    ex  = (d == 0) ? 0 : (e * pn) / (d * pd);
    tol = (d == 0) ? 0 : 2 * ((pn + pd - 1) / pd) + 2;
    chk_cnt("output toggles", ex, t, tol);
    wr(`FFL_ADDR_CTRL1, 16'h0008 | 16'(r[4] << 2));
    repeat (2) @(posedge i_clk);
    t = 0;
    repeat (100) begin
      @(posedge i_clk);
      #1;
      if (o_system_clock !== 1'b0) t++;
    end
    chk_cnt("output while disabled", 0, t, 0);
    chk("lock after disable", 16'h0000, {15'h0000, o_locked});
    rd(`FFL_ADDR_STATUS);
    chk("state after disable", 16'h0000, rd_val);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset = 1'b1;
    i_addr  = 8'h00;
    i_wdata = 16'h0000;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    test_reset_values();
    test_access();
    for (int k = 0; k < 8; k++) begin
      run_case(rows[k]);
    end
    end_sim();
  end

  // the whole run needs about 15000 cycles; 40000, over twice that, means a hang
  initial begin
    repeat (40000) @(posedge i_clk);
    bad_count++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
